// file: hwcp_cmd_parser.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Name-set command stores up to six characters, replies acknowledge or negative.
// - Two hex address characters follow the delimiter; only own address answers.
// - Broadcast host-alive is accepted by every module and never answered.
// - Host-alive restarts the watchdog from the configured timeout count.
// - Status read returns 00/04 while disabled, 10/14 while enabled.
// - Timeout flag kept in nonvolatile store; only status-reset clears it.
// - Status-reset clears flag, stops LED flashing, acknowledges with address.
// - Timeout read returns enable digit then two hex count digits.
// - Each timeout count step is 0.1 second.
// - Timeout set stores enable and count 01..FF, then acknowledges.
// - Expiry without host-alive sets the flag and flashes LED until cleared.
// - After expiry timeout read shows disabled but keeps the old count.
// - Starts in Modbus mode when the stored protocol is Modbus, unless strap held low at power-on.
// - Protocol set picks next power-up mode; query answers 10 or 11.
// - Start below channel count, start plus count within channel count.
// - Good read echoes address and function, byte count 2N, two bytes each.
// - Errors answer 0x84 with code 02 for bad start, 03 for range/length; other functions get function plus 0x80 with code 01.
module hwcp_cmd_parser #(
	parameter int TICK_CYCLES = hwcp_pkg::TICK_CYC,
	parameter int BLINK_TICKS = hwcp_pkg::BLINK_TICKS
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	output logic irq,
	input wire logic rx_valid,
	input wire hwcp_pkg::hwcp_byte_t rx,
	output logic tx_valid,
	output hwcp_pkg::hwcp_byte_t tx,
	input wire logic tx_ready,
	input wire logic init_strap_n,
	input wire hwcp_pkg::hwcp_nv_t nv_in,
	output logic nv_wr,
	output hwcp_pkg::hwcp_nv_t nv_out,
	output logic led,
	input wire logic [hwcp_pkg::MAX_CH*16-1:0] ch_data,
	output logic [hwcp_pkg::NAME_MAX*8-1:0] module_name
);
	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam int DEP = hwcp_pkg::BUF_DEPTH;

	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] v;
		v = 5'h00;
		if (c >= hwcp_pkg::CH_D0 && c <= hwcp_pkg::CH_D9) begin
			v = {1'b1, c[3:0]};
		end else if ((c >= hwcp_pkg::CH_UA && c <= hwcp_pkg::CH_UF) ||
			(c >= hwcp_pkg::CH_LA && c <= hwcp_pkg::CH_LF)) begin
			v = {1'b1, 4'(c[3:0] + 4'h9)};
		end
		return v;
	endfunction

	function automatic logic [8:0] hex2(input logic [7:0] hi, input logic [7:0] lo);
		logic [4:0] h;
		logic [4:0] l;
		h = hex_val(hi);
		l = hex_val(lo);
		return {h[4] & l[4], h[3:0], l[3:0]};
	endfunction

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		logic [7:0] c;
		c = (n < 4'ha) ? hwcp_pkg::CH_D0 + {4'h0, n} : hwcp_pkg::CH_ALPHA_OFS + {4'h0, n};
		return c;
	endfunction

	hwcp_pkg::hwcp_state_t state_ff;
	logic [7:0] buf_ff [DEP];
	logic [7:0] resp_ff [DEP];
	logic [4:0] len_ff;
	logic [4:0] rlen_ff;
	logic [3:0] idx_ff;
	logic ovf_ff;
	logic [1:0] ctrl_ff;
	logic [7:0] maddr_ff;
	logic [hwcp_pkg::IRQ_W-1:0] istat_ff;
	logic [hwcp_pkg::IRQ_W-1:0] imask_ff;
	logic mode_ff;
	logic proto_ff;
	logic flag_ff;
	logic wd_en_ff;
	logic [7:0] to_ff;
	logic [7:0] wd_cnt_ff;
	logic [PW-1:0] presc_ff;
	logic [3:0] blink_ff;
	logic phase_ff;
	logic led_ff;
	logic nv_wr_ff;
	logic [31:0] rd_ff;
	logic strap_s1_ff;
	logic strap_s2_ff;
	logic [1:0] boot_ff;
	logic [7:0] name_ff [hwcp_pkg::NAME_MAX];

	// Decode of the frame held in the buffer
	wire exec = (state_ff == hwcp_pkg::ST_EXEC);
	wire chk_en = ctrl_ff[hwcp_pkg::CTRL_CHK_BIT];
	wire [15:0] nch = ctrl_ff[hwcp_pkg::CTRL_SIX_BIT] ? hwcp_pkg::CH_WIDE : hwcp_pkg::CH_NARROW;
	wire [4:0] elen = (chk_en && len_ff >= 5'd2) ? 5'(len_ff - 5'd2) : len_ff;
	wire [8:0] chk_rx = hex2(buf_ff[elen[3:0]], buf_ff[4'(elen[3:0] + 4'h1)]);
	wire [8:0] adr_rx = hex2(buf_ff[1], buf_ff[2]);
	wire [8:0] vv_rx = hex2(buf_ff[5], buf_ff[6]);
	wire [7:0] dlm = buf_ff[0];
	wire [7:0] cmd = buf_ff[3];
	wire is_tilde = (dlm == hwcp_pkg::CH_TILDE);
	wire e_ok = (buf_ff[4] == hwcp_pkg::CH_D0) || (buf_ff[4] == hwcp_pkg::CH_D1);
	wire is_alive = is_tilde && buf_ff[1] == hwcp_pkg::CH_STAR &&
		buf_ff[2] == hwcp_pkg::CH_STAR && elen == 5'd3;
	wire addr_hit = adr_rx[8] && adr_rx[7:0] == maddr_ff && elen >= 5'd4;
	wire [15:0] mb_start = {buf_ff[2], buf_ff[3]};
	wire [15:0] mb_cnt = {buf_ff[4], buf_ff[5]};
	wire [16:0] mb_end = 17'(mb_start) + 17'(mb_cnt);
	wire tick = (presc_ff == PW'(TICK_CYCLES - 1));
	wire expire = wd_en_ff && tick && wd_cnt_ff <= 8'h01;
	logic [7:0] sum;
	logic [15:0] ch_word [hwcp_pkg::MAX_CH];
	logic [7:0] nxt_name [hwcp_pkg::NAME_MAX];

	genvar g;
	generate
		for (g = 0; g < hwcp_pkg::MAX_CH; g++) begin : g_ch
			assign ch_word[g] = ch_data[g*16 +: 16];
		end
		for (g = 0; g < hwcp_pkg::NAME_MAX; g++) begin : g_nm
			assign nxt_name[g] = (5'(g + 4) < elen) ? buf_ff[g + 4] : 8'h00;
			assign module_name[g*8 +: 8] = name_ff[g];
		end
	endgenerate

	always_comb begin
		sum = 8'h00;
		for (int i = 0; i < DEP; i++) begin
			if (5'(i) < elen) begin
				sum = sum + buf_ff[i];
			end
		end
	end

	wire chk_ok = !chk_en || (len_ff >= 5'd2 && chk_rx[8] && chk_rx[7:0] == sum);

	logic reply;
	logic [4:0] nxt_rlen;
	logic [7:0] nxt_resp [DEP];
	logic a_alive;
	logic a_name;
	logic a_clr;
	logic a_set;
	logic a_proto;
	logic a_discard;
	logic a_except;
	logic [2:0] ci;

	always_comb begin
		reply = 1'b0;
		nxt_rlen = 5'd0;
		a_alive = 1'b0;
		a_name = 1'b0;
		a_clr = 1'b0;
		a_set = 1'b0;
		a_proto = 1'b0;
		a_discard = 1'b0;
		a_except = 1'b0;
		ci = 3'h0;
		for (int i = 0; i < DEP; i++) begin
			nxt_resp[i] = 8'h00;
		end
		if (mode_ff) begin
			if (len_ff != 5'd0 && buf_ff[0] == maddr_ff) begin
				reply = 1'b1;
				nxt_resp[0] = buf_ff[0];
				nxt_resp[1] = buf_ff[1] | hwcp_pkg::MB_ERR_BIT;
				nxt_rlen = 5'd3;
				a_except = 1'b1;
				if (buf_ff[1] != hwcp_pkg::MB_FN_READ) begin
					nxt_resp[2] = hwcp_pkg::MB_EX_FUNC;
				end else if (len_ff != hwcp_pkg::MB_REQ_LEN) begin
					nxt_resp[2] = hwcp_pkg::MB_EX_RANGE;
				end else if (mb_start >= nch) begin
					nxt_resp[2] = hwcp_pkg::MB_EX_START;
				end else if (mb_cnt == 16'h0000 || mb_end > 17'(nch)) begin
					nxt_resp[2] = hwcp_pkg::MB_EX_RANGE;
				end else begin
					a_except = 1'b0;
					nxt_resp[1] = buf_ff[1];
					nxt_resp[2] = {mb_cnt[6:0], 1'b0};
					nxt_rlen = 5'(5'd3 + {mb_cnt[3:0], 1'b0});
					for (int j = 0; j < hwcp_pkg::MAX_CH; j++) begin
						ci = 3'(mb_start[2:0] + 3'(j));
						if (16'(j) < mb_cnt) begin
							nxt_resp[3 + 2*j] = ch_word[ci][15:8];
							nxt_resp[4 + 2*j] = ch_word[ci][7:0];
						end
					end
				end
			end
		end else if (ovf_ff || !chk_ok) begin
			a_discard = 1'b1;
		end else if (is_alive) begin
			a_alive = 1'b1;
		end else if (addr_hit) begin
			reply = 1'b1;
			nxt_resp[0] = hwcp_pkg::CH_ACK;
			nxt_resp[1] = hex_chr(maddr_ff[7:4]);
			nxt_resp[2] = hex_chr(maddr_ff[3:0]);
			nxt_resp[3] = hwcp_pkg::CH_CR;
			nxt_rlen = 5'd4;
			if (is_tilde && cmd == hwcp_pkg::CH_NAME && elen >= 5'd5 &&
				elen <= 5'(4 + hwcp_pkg::NAME_MAX)) begin
				a_name = 1'b1;
			end else if (is_tilde && cmd == hwcp_pkg::CH_D0 && elen == 5'd4) begin
				nxt_resp[3] = wd_en_ff ? hwcp_pkg::CH_D1 : hwcp_pkg::CH_D0;
				nxt_resp[4] = flag_ff ? hwcp_pkg::CH_D4 : hwcp_pkg::CH_D0;
				nxt_resp[5] = hwcp_pkg::CH_CR;
				nxt_rlen = 5'd6;
			end else if (is_tilde && cmd == hwcp_pkg::CH_D1 && elen == 5'd4) begin
				a_clr = 1'b1;
			end else if (is_tilde && cmd == hwcp_pkg::CH_D2 && elen == 5'd4) begin
				nxt_resp[3] = wd_en_ff ? hwcp_pkg::CH_D1 : hwcp_pkg::CH_D0;
				nxt_resp[4] = hex_chr(to_ff[7:4]);
				nxt_resp[5] = hex_chr(to_ff[3:0]);
				nxt_resp[6] = hwcp_pkg::CH_CR;
				nxt_rlen = 5'd7;
			end else if (is_tilde && cmd == hwcp_pkg::CH_D3 && elen == 5'd7 && e_ok &&
				vv_rx[8] && vv_rx[7:0] != 8'h00) begin
				a_set = 1'b1;
			end else if (dlm == hwcp_pkg::CH_DOLLAR && cmd == hwcp_pkg::CH_PROTO &&
				elen == 5'd4) begin
				nxt_resp[3] = hwcp_pkg::CH_D1;
				nxt_resp[4] = proto_ff ? hwcp_pkg::CH_D1 : hwcp_pkg::CH_D0;
				nxt_resp[5] = hwcp_pkg::CH_CR;
				nxt_rlen = 5'd6;
			end else if (dlm == hwcp_pkg::CH_DOLLAR && cmd == hwcp_pkg::CH_PROTO &&
				elen == 5'd5 && e_ok) begin
				a_proto = 1'b1;
			end else begin
				nxt_resp[0] = hwcp_pkg::CH_NAK;
			end
		end
	end

	// Frame collection, execution and reply sending
	wire rx_take = rx_valid && state_ff == hwcp_pkg::ST_RECV;
	wire rx_dlm = !mode_ff && (rx.data == hwcp_pkg::CH_TILDE || rx.data == hwcp_pkg::CH_DOLLAR);
	wire rx_end = mode_ff ? rx.last : (rx.data == hwcp_pkg::CH_CR);
	wire [3:0] wpos = rx_dlm ? 4'h0 : len_ff[3:0];
	wire tx_done = tx_ready && {1'b0, idx_ff} == 5'(rlen_ff - 5'd1);
	// Modbus frames store their terminating byte; ASCII drops the CR
	wire rx_store = rx_take && (mode_ff || !rx_end) && (rx_dlm || len_ff < 5'(DEP));

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= hwcp_pkg::ST_RECV;
		end else begin
			unique case (state_ff)
				hwcp_pkg::ST_RECV: if (rx_take && rx_end) state_ff <= hwcp_pkg::ST_EXEC;
				hwcp_pkg::ST_EXEC: state_ff <= reply ? hwcp_pkg::ST_SEND : hwcp_pkg::ST_RECV;
				hwcp_pkg::ST_SEND: if (tx_done) state_ff <= hwcp_pkg::ST_RECV;
				default: state_ff <= hwcp_pkg::ST_RECV;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			len_ff <= 5'd0;
			ovf_ff <= 1'b0;
			idx_ff <= 4'h0;
			rlen_ff <= 5'd0;
		end else begin
			if (exec) begin
				len_ff <= 5'd0;
				ovf_ff <= 1'b0;
				rlen_ff <= nxt_rlen;
				idx_ff <= 4'h0;
			end else if (rx_store) begin
				len_ff <= 5'({1'b0, wpos} + 5'd1);
				ovf_ff <= rx_dlm ? 1'b0 : ovf_ff;
			end else if (rx_take && !rx_end) begin
				ovf_ff <= 1'b1;
			end
			if (state_ff == hwcp_pkg::ST_SEND && tx_ready) idx_ff <= 4'(idx_ff + 4'h1);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEP; i++) begin
				buf_ff[i] <= 8'h00;
				resp_ff[i] <= 8'h00;
			end
		end else begin
			if (rx_store) buf_ff[wpos] <= rx.data;
			if (exec) resp_ff <= nxt_resp;
		end
	end

	assign tx_valid = (state_ff == hwcp_pkg::ST_SEND);
	assign tx.data = resp_ff[idx_ff];
	assign tx.last = tx_valid && {1'b0, idx_ff} == 5'(rlen_ff - 5'd1);

	// Strap sampled through a synchroniser, taken once after reset release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strap_s1_ff <= 1'b1;
			strap_s2_ff <= 1'b1;
			boot_ff <= 2'h0;
		end else begin
			strap_s1_ff <= init_strap_n;
			strap_s2_ff <= strap_s1_ff;
			if (boot_ff != 2'h3) boot_ff <= 2'(boot_ff + 2'h1);
		end
	end
	wire boot_take = (boot_ff == hwcp_pkg::BOOT_TAKE);

	// Watchdog, persistent flag and protocol choice
	wire wd_load = exec && (a_alive || a_set);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_ff <= 1'b0;
			proto_ff <= 1'b0;
			flag_ff <= 1'b0;
			wd_en_ff <= 1'b0;
			to_ff <= hwcp_pkg::TO_RST;
			wd_cnt_ff <= hwcp_pkg::TO_RST;
			presc_ff <= '0;
			nv_wr_ff <= 1'b0;
		end else begin
			nv_wr_ff <= (exec && (a_clr || a_proto)) || expire;
			if (boot_take) begin
				mode_ff <= nv_in.proto & strap_s2_ff;
				proto_ff <= nv_in.proto;
				flag_ff <= nv_in.flag;
			end else if (expire) begin
				flag_ff <= 1'b1;
			end else if (exec && a_clr) begin
				flag_ff <= 1'b0;
			end
			if (exec && a_proto) proto_ff <= buf_ff[4][0];
			if (exec && a_set) begin
				wd_en_ff <= buf_ff[4][0];
				to_ff <= vv_rx[7:0];
			end else if (expire) begin
				wd_en_ff <= 1'b0;
			end
			if (wd_load) begin
				presc_ff <= '0;
				wd_cnt_ff <= a_set ? vv_rx[7:0] : to_ff;
			end else begin
				presc_ff <= tick ? '0 : PW'(presc_ff + 1'b1);
				if (wd_en_ff && tick) wd_cnt_ff <= 8'(wd_cnt_ff - 8'h01);
			end
		end
	end

	// LED flashes from the 0.1 s tick while the flag stands
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			blink_ff <= 4'h0;
			phase_ff <= 1'b0;
			led_ff <= 1'b0;
		end else begin
			if (tick) begin
				blink_ff <= (blink_ff == 4'(BLINK_TICKS - 1)) ? 4'h0 : 4'(blink_ff + 4'h1);
				if (blink_ff == 4'(BLINK_TICKS - 1)) phase_ff <= !phase_ff;
			end
			led_ff <= flag_ff && phase_ff;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < hwcp_pkg::NAME_MAX; i++) begin
				name_ff[i] <= 8'h00;
			end
		end else if (exec && a_name) begin
			name_ff <= nxt_name;
		end
	end

	// Register port
	wire wr_ctrl = wr_en && addr == hwcp_pkg::OFF_CTRL;
	wire wr_addr = wr_en && addr == hwcp_pkg::OFF_ADDR;
	wire wr_istat = wr_en && addr == hwcp_pkg::OFF_ISTAT;
	wire wr_imask = wr_en && addr == hwcp_pkg::OFF_IMASK;
	wire [hwcp_pkg::IRQ_W-1:0] ev = {exec && a_except, exec && a_discard, expire, exec && a_alive};
	wire [hwcp_pkg::IRQ_W-1:0] w1c = wr_istat ? wr_data[hwcp_pkg::IRQ_W-1:0] : '0;
	logic [31:0] stat_word;
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[hwcp_pkg::STAT_FLAG_BIT] = flag_ff;
		stat_word[hwcp_pkg::STAT_EN_BIT] = wd_en_ff;
		stat_word[hwcp_pkg::STAT_MODE_BIT] = mode_ff;
		stat_word[hwcp_pkg::STAT_PROTO_BIT] = proto_ff;
		stat_word[hwcp_pkg::STAT_TO_LSB +: 8] = to_ff;
	end
	wire [31:0] rd_mux = (addr == hwcp_pkg::OFF_CTRL) ? {30'h0, ctrl_ff} :
		(addr == hwcp_pkg::OFF_ADDR) ? {24'h0, maddr_ff} :
		(addr == hwcp_pkg::OFF_STAT) ? stat_word :
		(addr == hwcp_pkg::OFF_ISTAT) ? {28'h0, istat_ff} :
		(addr == hwcp_pkg::OFF_IMASK) ? {28'h0, imask_ff} : 32'h0000_0000;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= hwcp_pkg::CTRL_RST;
			maddr_ff <= hwcp_pkg::ADDR_RST;
			istat_ff <= '0;
			imask_ff <= '0;
			rd_ff <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) ctrl_ff <= wr_data[1:0];
			if (wr_addr) maddr_ff <= wr_data[7:0];
			if (wr_imask) imask_ff <= wr_data[hwcp_pkg::IRQ_W-1:0];
			// Set after clear, so a same-cycle event survives
			istat_ff <= (istat_ff & ~w1c) | ev;
			rd_ff <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end

	assign rd_data = rd_ff;
	assign irq = |(istat_ff & imask_ff);
	assign led = led_ff;
	assign nv_wr = nv_wr_ff;
	assign nv_out.flag = flag_ff;
	assign nv_out.proto = proto_ff;
endmodule

// file: hwcp_cmd_parser_properties.sv
`timescale 1ns/10ps
module hwcp_cmd_parser_chk #(
	parameter int TICK_CYCLES = 10,
	parameter int BLINK_TICKS = 2
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	input wire logic rx_valid,
	input wire hwcp_pkg::hwcp_byte_t rx,
	input wire logic tx_valid,
	input wire hwcp_pkg::hwcp_byte_t tx,
	input wire logic tx_ready,
	input wire logic nv_wr,
	input wire hwcp_pkg::hwcp_nv_t nv_out,
	input wire logic led,
	input wire logic [hwcp_pkg::NAME_MAX*8-1:0] module_name
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	logic [3:0] cr_age_ff;
	logic [15:0] run_ff;
	logic led_d_ff;
	wire frame_end = rx_valid && (rx.data == hwcp_pkg::CH_CR || rx.last);
	wire [3:0] nxt_cr_age = frame_end ? 4'h0 : (&cr_age_ff ? cr_age_ff : cr_age_ff + 4'h1);
	// Cycles since the LED last moved while the flag is up
	wire [15:0] nxt_run = (!nv_out.flag || led != led_d_ff) ? 16'h0000 : run_ff + 16'h0001;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cr_age_ff <= 4'hf;
			run_ff <= 16'h0000;
			led_d_ff <= 1'b0;
		end else begin
			cr_age_ff <= nxt_cr_age;
			run_ff <= nxt_run;
			led_d_ff <= led;
		end
	end

	sequence alive_frame;
		rx_valid && rx.data == hwcp_pkg::CH_TILDE ##1 rx_valid && rx.data == hwcp_pkg::CH_STAR
		##1 rx_valid && rx.data == hwcp_pkg::CH_STAR ##1 rx_valid && rx.data == hwcp_pkg::CH_CR;
	endsequence

	a_reply_byte_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
		else $error("reply byte changed before it was taken");
	a_alive_no_reply: assert property (alive_frame |=> !tx_valid [*4])
		else $error("broadcast host alive was answered");
	a_reply_after_end: assert property ($rose(tx_valid) |-> $past(frame_end, 2))
		else $error("reply started without a frame end two cycles before");
	a_led_needs_flag: assert property (led |-> nv_out.flag || $past(nv_out.flag))
		else $error("led lit while timeout flag clear");
	a_led_keeps_flashing: assert property (run_ff <= 16'(2 * BLINK_TICKS * TICK_CYCLES))
		else $error("led stopped flashing while timeout flag set");
	a_flag_clear_cmd: assert property ($fell(nv_out.flag) |-> cr_age_ff <= 4'h4)
		else $error("timeout flag cleared without a command");
	a_name_by_cmd: assert property ($changed(module_name) |-> cr_age_ff <= 4'h4)
		else $error("module name changed without a command");
	a_store_pulse: assert property (nv_wr |=> !nv_wr)
		else $error("store request longer than one cycle");
	a_read_one_cycle: assert property (rd_data != '0 |-> $past(rd_en))
		else $error("read data outside the cycle after a read");
endmodule

bind hwcp_cmd_parser hwcp_cmd_parser_chk #(.TICK_CYCLES(TICK_CYCLES), .BLINK_TICKS(BLINK_TICKS)) u_chk (
	.mclk, .resetn, .rd_en, .rd_data, .rx_valid, .rx, .tx_valid, .tx, .tx_ready,
	.nv_wr, .nv_out, .led, .module_name
);

// file: hwcp_host_model.sv
`timescale 1ns/10ps
module hwcp_host_model (
	input wire logic mclk,
	output logic rx_valid,
	output hwcp_pkg::hwcp_byte_t rx,
	output logic tx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx = '0;
		tx_ready = 1'b0;
	end

	// Host drains replies unevenly, stalling about one byte in four
	always @(posedge mclk) begin
		tx_ready <= ($urandom_range(3) != 0);
	end

	task automatic send(input logic [7:0] f[$], input logic mb);
		for (int i = 0; i < f.size(); i++) begin
			rx_valid <= 1'b1;
			rx <= {f[i], mb && i == f.size() - 1};
			@(posedge mclk);
		end
		rx_valid <= 1'b0;
		// Released line shows the inverse so a stale byte cannot pass
		rx <= ~rx;
	endtask
endmodule

// file: hwcp_pkg.sv
package hwcp_pkg;
	// Register map, byte addresses of 32-bit words
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_ISTAT = 8'h0c;
	localparam logic [7:0] OFF_IMASK = 8'h10;
	localparam int CTRL_CHK_BIT = 0;
	localparam int CTRL_SIX_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [7:0] ADDR_RST = 8'h01;
	localparam int STAT_FLAG_BIT = 0;
	localparam int STAT_EN_BIT = 1;
	localparam int STAT_MODE_BIT = 2;
	localparam int STAT_PROTO_BIT = 3;
	localparam int STAT_TO_LSB = 8;
	localparam int IRQ_ALIVE = 0;
	localparam int IRQ_EXPIRE = 1;
	localparam int IRQ_DISCARD = 2;
	localparam int IRQ_EXCEPT = 3;
	localparam int IRQ_W = 4;
	localparam logic [7:0] TO_RST = 8'h01;

	// Frame layout and sizes
	localparam int BUF_DEPTH = 16;
	localparam int NAME_MAX = 6;
	localparam int MAX_CH = 6;
	localparam logic [15:0] CH_NARROW = 16'h0003;
	localparam logic [15:0] CH_WIDE = 16'h0006;
	localparam logic [4:0] MB_REQ_LEN = 5'h06;

	// Characters
	localparam logic [7:0] CH_TILDE = 8'h7e;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_ACK = 8'h21;
	localparam logic [7:0] CH_NAK = 8'h3f;
	localparam logic [7:0] CH_NAME = 8'h4f;
	localparam logic [7:0] CH_PROTO = 8'h50;
	localparam logic [7:0] CH_D0 = 8'h30;
	localparam logic [7:0] CH_D1 = 8'h31;
	localparam logic [7:0] CH_D2 = 8'h32;
	localparam logic [7:0] CH_D3 = 8'h33;
	localparam logic [7:0] CH_D4 = 8'h34;
	localparam logic [7:0] CH_D9 = 8'h39;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UF = 8'h46;
	localparam logic [7:0] CH_LA = 8'h61;
	localparam logic [7:0] CH_LF = 8'h66;
	localparam logic [7:0] CH_ALPHA_OFS = 8'h37;

	// Modbus codes
	localparam logic [7:0] MB_FN_READ = 8'h04;
	localparam logic [7:0] MB_ERR_BIT = 8'h80;
	localparam logic [7:0] MB_EX_FUNC = 8'h01;
	localparam logic [7:0] MB_EX_START = 8'h02;
	localparam logic [7:0] MB_EX_RANGE = 8'h03;

	// Timing: watchdog step 0.1 s at a 100 ns clock
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 100000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int BLINK_TICKS = 5;
	localparam logic [1:0] BOOT_TAKE = 2'h2;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hwcp_byte_t;

	typedef struct packed {
		logic flag;
		logic proto;
	} hwcp_nv_t;

	typedef enum logic [1:0] {
		ST_RECV = 2'b00,
		ST_EXEC = 2'b01,
		ST_SEND = 2'b10
	} hwcp_state_t;
endpackage

// file: test_hwcp_cmd_parser.sv
`timescale 1ns/10ps
module test_hwcp_cmd_parser;
	logic mclk, resetn, wr_en, rd_en, irq, rx_valid, tx_valid, tx_ready;
	logic init_strap_n, nv_wr, led, rd_seen;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data;
	hwcp_pkg::hwcp_byte_t rx, tx;
	hwcp_pkg::hwcp_nv_t nv_in, nv_out;
	logic [95:0] ch_data;
	logic [47:0] module_name;
	hwcp_pkg::hwcp_byte_t exp_q[$];
	logic [31:0] rd_q[$];
	int fails = 0;
	int n_compared = 0;
	int n_store = 0;
	int r;

	hwcp_cmd_parser #(.TICK_CYCLES(10), .BLINK_TICKS(2)) u_hwcp_cmd_parser (
		.mclk, .resetn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq, .rx_valid, .rx,
		.tx_valid, .tx, .tx_ready, .init_strap_n, .nv_in, .nv_wr, .nv_out, .led, .ch_data,
		.module_name
	);
	hwcp_host_model u_hwcp_host_model (.mclk, .rx_valid, .rx, .tx_ready);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp(string nm, logic [47:0] e, logic [47:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	always @(posedge mclk) begin
		rd_seen <= rd_en;
		if (nv_wr === 1'b1) n_store++;
		if (rd_seen === 1'b1) cmp("rd_data", rd_q.pop_front(), rd_data);
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (exp_q.size() == 0) cmp("extra reply byte", '1, 48'(tx));
			else cmp("reply byte", 48'(exp_q.pop_front()), 48'(tx));
		end
	end

	task automatic wr(logic [7:0] a, logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e);
		rd_q.push_back(e);
		addr <= a;
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic idle(int n);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (n) @(posedge mclk);
	endtask

	task automatic frame(logic [7:0] f[$], logic [7:0] rp[$], logic mb);
		int n;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		foreach (rp[i]) exp_q.push_back({rp[i], i == rp.size() - 1});
		u_hwcp_host_model.send(f, mb);
		n = 0;
		repeat (6) @(posedge mclk);
		while ((exp_q.size() != 0 || tx_valid === 1'b1) && n < 400) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 400) cmp("reply wait", 48'h0, 48'h1);
	endtask

	task automatic ascii(string c, string rs);
		logic [7:0] f[$];
		logic [7:0] rp[$];
		for (int i = 0; i < c.len(); i++) f.push_back(c[i]);
		f.push_back(hwcp_pkg::CH_CR);
		for (int i = 0; i < rs.len(); i++) rp.push_back(rs[i]);
		if (rs.len() != 0) rp.push_back(hwcp_pkg::CH_CR);
		frame(f, rp, 1'b0);
	endtask

	task automatic mbread(logic [7:0] a, logic [15:0] s, logic [15:0] n, int nch);
		logic [7:0] rp[$];
		if (a != 8'h01) rp = {};
		else if (s >= nch) rp = {8'h01, 8'h84, 8'h02};
		else if (n == 0 || s + n > nch) rp = {8'h01, 8'h84, 8'h03};
		else begin
			rp = {8'h01, 8'h04, 8'(2 * n)};
			for (int k = s; k < s + n; k++) begin
				rp.push_back(ch_data[16 * k + 8 +: 8]);
				rp.push_back(ch_data[16 * k +: 8]);
			end
		end
		frame({a, 8'h04, s[15:8], s[7:0], n[15:8], n[7:0]}, rp, 1'b1);
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		print_verdict();
	end

	initial begin
		resetn <= 1'b0;
		addr <= 8'h00;
		wr_data <= 32'h0;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		init_strap_n <= 1'b0;
		nv_in <= 2'b01;
		r = $urandom(32'hcc56);
		ch_data <= {$urandom(), $urandom(), $urandom()};
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		idle(6);
		rd(hwcp_pkg::OFF_CTRL, 32'h2);
		rd(hwcp_pkg::OFF_ADDR, 32'h1);
		rd(hwcp_pkg::OFF_STAT, 32'h0108);
		wr(hwcp_pkg::OFF_STAT, '1);
		rd(hwcp_pkg::OFF_STAT, 32'h0108);
		rd(8'h14, 32'h0);
		wr(hwcp_pkg::OFF_IMASK, 32'h2);
		idle(2);
		$display("test registers done");
		ascii("~010", "!0100");
		ascii("~01310A", "!01");
		ascii("~012", "!0110A");
		ascii("~020", "");
		repeat (5) ascii("~**", "");
		ascii("~010", "!0110");
		cmp("irq masked", 48'h0, 48'(irq));
		idle(150);
		cmp("irq", 48'h1, 48'(irq));
		cmp("flag", 48'h1, 48'(nv_out.flag));
		ascii("~010", "!0104");
		ascii("~012", "!0100A");
		rd(hwcp_pkg::OFF_STAT, 32'h0a09);
		wr(hwcp_pkg::OFF_ISTAT, 32'h2);
		idle(2);
		cmp("irq cleared", 48'h0, 48'(irq));
		wr(hwcp_pkg::OFF_IMASK, 32'h1);
		idle(2);
		cmp("irq alive", 48'h1, 48'(irq));
		ascii("~011", "!01");
		idle(4);
		cmp("led", 48'h0, 48'(led));
		cmp("flag", 48'h0, 48'(nv_out.flag));
		$display("test watchdog done");
		ascii("~01O7351", "!01");
		cmp("name", 48'h0000_3135_3337, module_name);
		ascii("~01O1234567", "?01");
		ascii("$01P", "!0111");
		ascii("$01P0", "!01");
		cmp("saved proto", 48'h0, 48'(nv_out.proto));
		ascii("$01P", "!0110");
		wr(hwcp_pkg::OFF_ISTAT, '1);
		wr(hwcp_pkg::OFF_CTRL, 32'h3);
		wr(hwcp_pkg::OFF_IMASK, 32'h4);
		ascii("~01000", "");
		cmp("irq discard", 48'h1, 48'(irq));
		ascii("~0100F", "!0100");
		$display("test name and checksum done");
		resetn <= 1'b0;
		init_strap_n <= 1'b1;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		idle(6);
		rd(hwcp_pkg::OFF_STAT, 32'h010c);
		wr(hwcp_pkg::OFF_IMASK, 32'h8);
		mbread(8'h01, 16'h0, 16'h6, 6);
		mbread(8'h01, 16'h5, 16'h1, 6);
		mbread(8'h01, 16'h6, 16'h1, 6);
		mbread(8'h01, 16'h4, 16'h3, 6);
		mbread(8'h01, 16'h0, 16'h0, 6);
		mbread(8'h02, 16'h0, 16'h1, 6);
		for (int i = 0; i < 8; i++) mbread(8'h01, 16'($urandom_range(7)), 16'($urandom_range(7)), 6);
		frame({8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h01, 8'h83, 8'h01}, 1'b1);
		frame({8'h01, 8'h04, 8'h00, 8'h00, 8'h00}, {8'h01, 8'h84, 8'h03}, 1'b1);
		cmp("irq except", 48'h1, 48'(irq));
		wr(hwcp_pkg::OFF_CTRL, 32'h0);
		mbread(8'h01, 16'h2, 16'h1, 3);
		mbread(8'h01, 16'h3, 16'h1, 3);
		mbread(8'h01, 16'h1, 16'h3, 3);
		// Clear, protocol set and one expiry each ask for a save
		cmp("store requests", 48'd3, 48'(n_store));
		$display("test modbus done");
		print_verdict();
	end
endmodule
